// *** design/mmutb_bus_if.sv ***
// Behaviour
// [R1] fast strap low: searches use translation strobe edge
// [R2] fast strap high: search strobe one clock
// [R3] early startup begins exception hardware on detection
// [R4] early mode: grant waits up to eight clocks
// [R5] early strap low: startup waits for acknowledge
// [R6] external arbitration bypass needs early strap low
// [R7] inhibit strap sets inhibit on device cycles
// [R8] low address lines sampled every cycle
// [R9] initial shift masks upper logical bits
// [R10] CPU space keeps address bits up to nineteen
// [R11] extra page offset bits pass through unchanged
// [R12] upper physical address driven while bus owned
// [R13] master holds logical strobe until termination
// [R14] good translation outside CPU space asserts strobe
// [R15] foreign CPU space: pass address, inhibit, no strobe
// [R16] own CPU space: no strobe, no inhibit
// [R17] untranslatable cycle: fault, hold-off, request together
// [R18] forbidden cycle or disabled breakpoint: fault
// [R19] register access: data and size acknowledge in the same clock
// [R20] searching register access: request, hold-off, then acknowledge
// [R21] restart or descriptor miss: fault, hold-off, request
// [R22] straps captured from low data byte at reset
// [R23] timeout straps add zero to three half clocks
// [R24] physical strobe drops right after logical strobe
// [R25] synchronous mode: strobe one clock after edge
// [R26] straps stay fixed until next reset
module mmutb_bus_if
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] data_low,
  input wire logic async_mode,
  input wire logic logical_addr_strobe,
  input wire logic [23:0] logical_upper_addr,
  input wire logic [7:0] shared_low_addr,
  input wire logic [3:0] initial_shift_field,
  input wire logic [2:0] page_extra_bits,
  input wire logic cpu_space,
  input wire logic target_self,
  input wire logic bkpt_ack_cycle,
  input wire logic bkpt_enabled,
  input wire logic xlat_hit,
  input wire logic [23:0] xlat_page,
  input wire logic xlat_violation,
  input wire logic reg_needs_search,
  input wire logic reg_restart_search,
  input wire logic reg_write,
  input wire logic [31:0] reg_read_data,
  input wire logic [31:0] data_in,
  input wire logic search_cycle,
  input wire logic [23:0] search_addr,
  input wire logic search_done,
  input wire logic phys_bus_owned,
  input wire logic logical_request_in,
  input wire logic logical_grant_acknowledge,
  output logic [23:0] lookup_addr,
  output logic [7:0] reg_select,
  output logic [23:0] physical_upper_addr,
  output logic phys_addr_oe,
  output logic physical_addr_strobe,
  output logic strobe_on_rising,
  output logic cache_load_inhibit,
  output logic bus_fault,
  output logic hold_off,
  output logic logical_request_out,
  output logic logical_grant_out,
  output logic [1:0] size_acknowledge,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic [31:0] reg_write_data,
  output logic exc_active
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DRIVE} mmutb_st_type;

  function automatic logic [1:0] dly_half(input logic [1:0] code);
    case (code)
      2'h0: dly_half = mmutb_pkg::DLY_HALF_00;
      2'h1: dly_half = mmutb_pkg::DLY_HALF_01;
      2'h2: dly_half = mmutb_pkg::DLY_HALF_10;
      default: dly_half = mmutb_pkg::DLY_HALF_11;
    endcase
  endfunction : dly_half

  function automatic logic [1:0] sack_code(input logic [1:0] code);
    case (code)
      2'h1: sack_code = mmutb_pkg::SACK_8;
      2'h2: sack_code = mmutb_pkg::SACK_16;
      default: sack_code = mmutb_pkg::SACK_32;
    endcase
  endfunction : sack_code

  logic [7:0] straps;
  logic strap_done;
  logic las_sync;
  mmutb_st_type st_ff;
  mmutb_st_type nxt_st;
  mmutb_pkg::mmutb_cls_type cls_ff;
  mmutb_pkg::mmutb_cls_type cls_now;
  logic las_d_ff;
  logic src_d_ff;
  logic [1:0] cnt_ff;
  logic pas_ff, cli_ff, fault_ff, hold_ff, lreq_ff;
  logic [1:0] sack_ff;
  logic ack_pend_ff;
  logic [23:0] paddr_ff;
  logic [7:0] rsel_ff;
  logic [31:0] dout_ff;
  logic doe_ff;
  logic [31:0] wdata_ff;
  logic exc_pend_ff, exc_act_ff;
  logic [3:0] exc_cnt_ff;
  logic [3:0] idle_cnt_ff;
  logic grant_ff;
  logic srch_rise_hold;

  mmutb_strap_latch u_straps
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .data_low(data_low),
    .straps(straps),
    .strap_done(strap_done)
  );

  mmutb_sync3 u_las_sync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(logical_addr_strobe),
    .dout(las_sync)
  );

  wire fast_off = straps[mmutb_pkg::STRAP_FAST];
  wire early_on = straps[mmutb_pkg::STRAP_EARLY];
  wire inhibit_on = straps[mmutb_pkg::STRAP_INHIBIT];
  wire [1:0] bus_code = {straps[mmutb_pkg::STRAP_BUS_HI],
                         straps[mmutb_pkg::STRAP_BUS_LO]};
  wire [1:0] dly_code = {straps[mmutb_pkg::STRAP_DLY_HI],
                         straps[mmutb_pkg::STRAP_DLY_LO]};
  wire [2:0] xl_half = mmutb_pkg::BASE_HALF + {1'b0, dly_half(dly_code)};
  // half clocks round up to whole clocks on a single clock
  wire [1:0] xl_cyc = 2'((xl_half + 3'h1) >> 1); // R23
  wire [1:0] srch_cyc = fast_off ? 2'h1 : xl_cyc; // R1 R2
  // synchronous mode uses the raw strobe, relying on master timing
  wire las_s = async_mode ? las_sync : logical_addr_strobe; // R25
  wire src_now = las_s | search_cycle;
  wire las_rise = las_s & ~las_d_ff;
  wire srch_rise = search_cycle & ~src_d_ff & ~las_s;
  wire start = (las_rise | srch_rise) & (st_ff == ST_IDLE);
  wire [1:0] cyc_sel = srch_rise ? srch_cyc : xl_cyc;
  wire fire = (start & (cyc_sel == 2'h1)) |
              ((st_ff == ST_WAIT) & (cnt_ff == 2'h1));
  wire src_gone = (st_ff != ST_IDLE) & ~src_now;
  wire [23:0] is_mask = (mmutb_pkg::ADDR_ALL >> initial_shift_field) |
                        (cpu_space ? mmutb_pkg::CPU_KEEP : 24'h000000); // R9 R10
  wire [23:0] off_mask = 24'((25'h1 << page_extra_bits) - 25'h1);
  wire [23:0] xl_addr = (xlat_page & ~off_mask) |
                        (logical_upper_addr & off_mask); // R11
  wire need_search = (las_s & ~cpu_space & ~xlat_hit) |
                     (las_s & cpu_space & target_self & reg_needs_search);

  assign lookup_addr = logical_upper_addr & is_mask; // R9
  assign reg_select = rsel_ff;

  // class of the cycle at the strobe decision point
  always_comb
  begin
    if (search_cycle & ~las_s)
      cls_now = mmutb_pkg::CLS_SEARCH;
    else if (cpu_space & ~target_self)
      cls_now = mmutb_pkg::CLS_CPU_OTHER; // R15
    else if (cpu_space & bkpt_ack_cycle & ~bkpt_enabled)
      cls_now = mmutb_pkg::CLS_FAULT; // R18
    else if (cpu_space & reg_restart_search)
      cls_now = mmutb_pkg::CLS_RETRY; // R21
    else if (cpu_space & reg_needs_search)
      cls_now = mmutb_pkg::CLS_REG_SEARCH; // R20
    else if (cpu_space)
      cls_now = mmutb_pkg::CLS_REG; // R16
    else if (~xlat_hit)
      cls_now = mmutb_pkg::CLS_RETRY; // R17
    else if (xlat_violation)
      cls_now = mmutb_pkg::CLS_FAULT; // R18
    else
      cls_now = mmutb_pkg::CLS_XLAT; // R14
  end

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (fire)
          nxt_st = ST_DRIVE;
        else if (start)
          nxt_st = ST_WAIT;
      ST_WAIT:
        if (~src_now)
          nxt_st = ST_IDLE;
        else if (fire)
          nxt_st = ST_DRIVE;
      ST_DRIVE:
        if (~src_now)
          nxt_st = ST_IDLE; // R13
      default:
        nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ST_IDLE;
      cls_ff <= mmutb_pkg::CLS_XLAT;
      cnt_ff <= 2'h0;
      las_d_ff <= 1'b0;
      src_d_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      las_d_ff <= las_s;
      src_d_ff <= search_cycle;
      if (start)
        cnt_ff <= 2'(cyc_sel - 2'h1);
      else if (st_ff == ST_WAIT)
        cnt_ff <= 2'(cnt_ff - 2'h1);
      if (fire)
        cls_ff <= cls_now;
    end
  end

  // bus control strobes; all drop with the strobe that caused them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pas_ff <= 1'b0;
      cli_ff <= 1'b0;
      fault_ff <= 1'b0;
      hold_ff <= 1'b0;
      lreq_ff <= 1'b0;
      sack_ff <= 2'h0;
      ack_pend_ff <= 1'b0;
    end
    else if (src_gone)
    begin
      pas_ff <= 1'b0; // R24
      cli_ff <= 1'b0;
      fault_ff <= 1'b0;
      hold_ff <= 1'b0;
      lreq_ff <= 1'b0;
      sack_ff <= 2'h0;
      ack_pend_ff <= 1'b0;
    end
    else if (fire)
    begin
      case (cls_now)
        mmutb_pkg::CLS_XLAT:
        begin
          pas_ff <= 1'b1; // R14
          cli_ff <= 1'b0;
        end
        mmutb_pkg::CLS_SEARCH:
        begin
          pas_ff <= 1'b1; // R2
          cli_ff <= inhibit_on; // R7
        end
        mmutb_pkg::CLS_CPU_OTHER:
          cli_ff <= 1'b1; // R15
        mmutb_pkg::CLS_FAULT:
          fault_ff <= 1'b1; // R18
        mmutb_pkg::CLS_RETRY:
        begin
          fault_ff <= 1'b1; // R17 R21
          hold_ff <= 1'b1;
          lreq_ff <= 1'b1;
        end
        mmutb_pkg::CLS_REG_SEARCH:
        begin
          hold_ff <= 1'b1; // R20
          lreq_ff <= 1'b1;
          ack_pend_ff <= 1'b1;
        end
        mmutb_pkg::CLS_REG:
          sack_ff <= sack_code(bus_code); // R19
        default:
          pas_ff <= 1'b0;
      endcase
    end
    else if (ack_pend_ff)
    begin
      sack_ff <= sack_code(bus_code); // R20
      ack_pend_ff <= 1'b0;
    end
  end

  // address path and register data lanes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      paddr_ff <= 24'h000000;
      rsel_ff <= 8'h00;
      dout_ff <= 32'h00000000;
      doe_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
    end
    else
    begin
      rsel_ff <= shared_low_addr; // R8
      if (search_cycle & ~las_s)
        paddr_ff <= search_addr;
      else if (cpu_space)
        paddr_ff <= logical_upper_addr; // R15
      else
        paddr_ff <= xl_addr; // R12
      doe_ff <= 1'b0;
      if (fire & (cls_now == mmutb_pkg::CLS_REG))
      begin
        if (reg_write)
          wdata_ff <= data_in; // R19
        else
        begin
          dout_ff <= reg_read_data; // R19
          doe_ff <= 1'b1;
        end
      end
      else if (doe_ff & ~src_gone)
        doe_ff <= 1'b1;
    end
  end

  // exception hardware startup and logical bus grant
  wire exc_kick = early_on ? need_search & ~exc_pend_ff & ~exc_act_ff
                           : 1'b0; // R3
  wire ack_kick = ~early_on & exc_pend_ff & logical_grant_acknowledge; // R5
  wire grant_ok = ~early_on | ~exc_act_ff | (idle_cnt_ff == 4'h1);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_pend_ff <= 1'b0;
      exc_act_ff <= 1'b0;
      exc_cnt_ff <= 4'h0;
      idle_cnt_ff <= 4'h0;
      grant_ff <= 1'b0;
    end
    else
    begin
      if (~early_on & need_search & ~exc_act_ff)
        exc_pend_ff <= 1'b1;
      if (exc_kick | ack_kick)
      begin
        exc_pend_ff <= 1'b0;
        exc_act_ff <= 1'b1;
        exc_cnt_ff <= mmutb_pkg::STARTUP_CLKS; // R3 R5
      end
      else if (search_done | (idle_cnt_ff == 4'h1))
        exc_act_ff <= 1'b0;
      else if (exc_cnt_ff != 4'h0)
        exc_cnt_ff <= 4'(exc_cnt_ff - 4'h1);
      // idling the exception hardware delays the grant
      if (logical_request_in & early_on & exc_act_ff & ~grant_ff &
          (idle_cnt_ff == 4'h0))
        idle_cnt_ff <= mmutb_pkg::IDLE_CLKS; // R4
      else if (idle_cnt_ff != 4'h0)
        idle_cnt_ff <= 4'(idle_cnt_ff - 4'h1);
      grant_ff <= logical_request_in & (grant_ff | grant_ok); // R4 R6
    end
  end

  assign physical_upper_addr = paddr_ff;
  assign phys_addr_oe = phys_bus_owned; // R12
  assign physical_addr_strobe = pas_ff;
  assign srch_rise_hold = (cls_ff == mmutb_pkg::CLS_SEARCH) & fast_off;
  assign strobe_on_rising = ~dly_code[0] & ~srch_rise_hold; // R1 R23
  assign cache_load_inhibit = cli_ff;
  assign bus_fault = fault_ff;
  assign hold_off = hold_ff;
  assign logical_request_out = lreq_ff;
  assign logical_grant_out = grant_ff;
  assign size_acknowledge = sack_ff;
  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign reg_write_data = wdata_ff;
  assign exc_active = exc_act_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_search_fast_pas: assert property ( // R2
    $rose(search_cycle) && !las_s && st_ff == ST_IDLE && fast_off
    |=> physical_addr_strobe) else $error("fast search strobe late");
  a_sync_pas_delay: assert property ( // R25
    start && las_rise && cls_now == mmutb_pkg::CLS_XLAT && xl_cyc == 2'h1
    |=> physical_addr_strobe) else $error("strobe not one clock late");
  a_xlat_pas_window: assert property ( // R1
    start && cls_now == mmutb_pkg::CLS_XLAT
    |-> ##[1:3] (physical_addr_strobe || !src_now))
    else $error("translation strobe missing");
  a_retry_trio: assert property ( // R17
    $rose(hold_off) && bus_fault |-> logical_request_out)
    else $error("retry signals not together");
  a_cpu_other: assert property ( // R15
    st_ff == ST_DRIVE && cls_ff == mmutb_pkg::CLS_CPU_OTHER && src_now
    |-> cache_load_inhibit && !physical_addr_strobe)
    else $error("foreign cpu space cycle wrong");
  a_self_quiet: assert property ( // R16
    cls_ff == mmutb_pkg::CLS_REG && st_ff == ST_DRIVE
    |-> !physical_addr_strobe && !cache_load_inhibit)
    else $error("own register cycle strobed");
  a_pas_negate: assert property ( // R24
    physical_addr_strobe && !src_now |=> !physical_addr_strobe)
    else $error("strobe held after logical strobe");
  a_reg_order: assert property ( // R20
    $rose(size_acknowledge != 2'h0) && cls_ff == mmutb_pkg::CLS_REG_SEARCH
    |-> $past(logical_request_out) && $past(hold_off))
    else $error("acknowledge before request");
  a_straps_hold: assert property ( // R26
    strap_done && $past(strap_done) |-> $stable(straps))
    else $error("straps changed");
  a_grant_bound: assert property ( // R4
    $rose(logical_request_in)
    |-> ##[1:10] (logical_grant_out || !logical_request_in))
    else $error("grant delayed too long");
  a_cli_strap: assert property ( // R7
    physical_addr_strobe && cls_ff == mmutb_pkg::CLS_SEARCH
    |-> cache_load_inhibit == inhibit_on)
    else $error("inhibit disagrees with strap");
  c_xlat: cover property (physical_addr_strobe && cls_ff ==
    mmutb_pkg::CLS_XLAT);
  c_retry: cover property (bus_fault && hold_off);
  c_reg_ack: cover property (size_acknowledge != 2'h0);
  c_grant: cover property (logical_grant_out && exc_act_ff);
  c_startup: cover property (exc_act_ff && exc_cnt_ff == 4'h1);
endmodule : mmutb_bus_if

// *** common/mmutb_pkg.sv ***
package mmutb_pkg;
  // strap positions in the low data byte captured at reset release
  localparam int STRAP_BUS_LO = 1;
  localparam int STRAP_BUS_HI = 2;
  localparam int STRAP_DLY_LO = 3;
  localparam int STRAP_DLY_HI = 4;
  localparam int STRAP_FAST = 5;
  localparam int STRAP_EARLY = 6;
  localparam int STRAP_INHIBIT = 7;
  localparam logic [7:0] STRAP_RESET = 8'hFF;
  // timeout delay in half clocks per {hi,lo} strap code
  localparam logic [1:0] DLY_HALF_00 = 2'h3;
  localparam logic [1:0] DLY_HALF_01 = 2'h2;
  localparam logic [1:0] DLY_HALF_10 = 2'h1;
  localparam logic [1:0] DLY_HALF_11 = 2'h0;
  // strobe normally one clock (two half clocks) after the strobe edge
  localparam logic [2:0] BASE_HALF = 3'h2;
  localparam logic [3:0] STARTUP_CLKS = 4'h6;
  localparam logic [3:0] IDLE_CLKS = 4'h8;
  // size acknowledge per {hi,lo} bus size strap code, asserted = 1
  localparam logic [1:0] SACK_32 = 2'h3;
  localparam logic [1:0] SACK_16 = 2'h2;
  localparam logic [1:0] SACK_8 = 2'h1;
  localparam logic [23:0] ADDR_ALL = 24'hFFFFFF;
  // logical bits 8..19 stay visible in CPU space
  localparam logic [23:0] CPU_KEEP = 24'h000FFF;
  typedef enum logic [2:0] {
    CLS_XLAT, CLS_FAULT, CLS_RETRY, CLS_CPU_OTHER,
    CLS_REG, CLS_REG_SEARCH, CLS_SEARCH
  } mmutb_cls_type;
endpackage : mmutb_pkg

// *** design/mmutb_sync3.sv ***
module mmutb_sync3
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      out_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // a change counts only once two stages agree
      if (s2_ff == s3_ff)
        out_ff <= s3_ff;
    end
  end

  assign dout = out_ff;
endmodule : mmutb_sync3

// *** design/mmutb_strap_latch.sv ***
module mmutb_strap_latch
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] data_low,
  output logic [7:0] straps,
  output logic strap_done
);
  logic [7:0] straps_ff;
  logic done_ff;

  // captured on the first edge after release; async reset takes constants
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      straps_ff <= mmutb_pkg::STRAP_RESET;
      done_ff <= 1'b0;
    end
    else if (!done_ff)
    begin
      straps_ff <= data_low; // R22
      done_ff <= 1'b1; // R26
    end
  end

  assign straps = straps_ff;
  assign strap_done = done_ff;
endmodule : mmutb_strap_latch

// *** tb/mmutb_master.sv ***
module mmutb_master
(
  input wire logic core_clk,
  input wire logic go,
  input wire logic [23:0] addr,
  input wire logic [7:0] low,
  input wire logic [3:0] ext_wait,
  input wire logic bus_fault,
  input wire logic [1:0] size_acknowledge,
  output logic logical_addr_strobe,
  output logic [23:0] logical_upper_addr,
  output logic [7:0] shared_low_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic g;
  logic t;
  int cnt;
  initial
  begin
    logical_addr_strobe = 1'h0;
    logical_upper_addr = 24'h0;
    shared_low_addr = 8'h0;
    cnt = 0;
  end
  // sample at the edge, drive just after it
  always @(posedge core_clk)
  begin
    g = go;
    t = bus_fault | (|size_acknowledge) | (cnt >= int'(ext_wait));
    #1;
    if (logical_addr_strobe && t)
    begin
      logical_addr_strobe = 1'h0;
      // released lines must not keep the old value
      logical_upper_addr = ~logical_upper_addr;
      shared_low_addr = ~shared_low_addr;
    end
    else if (!logical_addr_strobe && g)
    begin
      logical_addr_strobe = 1'h1;
      logical_upper_addr = addr;
      shared_low_addr = low;
      cnt = 0;
    end
    cnt = cnt + 1;
  end
endmodule : mmutb_master

// *** tb/mmu_translation_bus_interface_bench.sv ***
module mmu_translation_bus_interface_bench;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] data_low = 8'hFF;
  logic async_mode = 1'h0;
  logic go = 1'h0;
  logic [23:0] addr = 24'h0, xlat_page = 24'h0, search_addr = 24'h0;
  logic [7:0] low = 8'h0;
  logic [3:0] initial_shift_field = 4'h0;
  logic [2:0] page_extra_bits = 3'h0;
  logic cpu_space = 1'h0, target_self = 1'h0, bkpt_ack_cycle = 1'h0;
  logic bkpt_enabled = 1'h0, xlat_hit = 1'h0, xlat_violation = 1'h0;
  logic reg_needs_search = 1'h0, reg_restart_search = 1'h0;
  logic reg_write = 1'h0, search_cycle = 1'h0, search_done = 1'h0;
  logic [31:0] reg_read_data = 32'h0, data_in = 32'h0;
  logic phys_bus_owned = 1'h1, logical_request_in = 1'h0;
  logic logical_grant_acknowledge = 1'h0;
  logic logical_addr_strobe, phys_addr_oe, physical_addr_strobe;
  logic strobe_on_rising, cache_load_inhibit, bus_fault, hold_off;
  logic logical_request_out, logical_grant_out, data_oe, exc_active;
  logic [23:0] logical_upper_addr, lookup_addr, physical_upper_addr;
  logic [7:0] shared_low_addr, reg_select;
  logic [1:0] size_acknowledge;
  logic [31:0] data_out, reg_write_data;
  logic [31:0] seed = 32'h41F13B52;
  // {cpu, self, bkpt, hit, violation, needs search, restart, write}
  logic [7:0] ctab [10] = '{8'h10, 8'h90, 8'hD0, 8'hD1, 8'hD4, 8'hD2,
    8'h00, 8'h18, 8'hF0, 8'h00};
  // {strobe, inhibit, fault, hold-off, request} seen during the cycle
  logic [4:0] etab [10] = '{5'h10, 5'h08, 5'h00, 5'h00, 5'h03, 5'h07,
    5'h07, 5'h04, 5'h04, 5'h10};
  int n_fail = 0, n_checks = 0;
  int code, nclk, fast, inh, early, bus, lag;

  always #5 core_clk = ~core_clk;

  mmutb_bus_if mmutb_bus_if_i (.core_clk, .rst_n, .data_low, .async_mode,
    .logical_addr_strobe, .logical_upper_addr, .shared_low_addr,
    .initial_shift_field, .page_extra_bits, .cpu_space, .target_self,
    .bkpt_ack_cycle, .bkpt_enabled, .xlat_hit, .xlat_page, .xlat_violation,
    .reg_needs_search, .reg_restart_search, .reg_write, .reg_read_data,
    .data_in, .search_cycle, .search_addr, .search_done, .phys_bus_owned,
    .logical_request_in, .logical_grant_acknowledge, .lookup_addr,
    .reg_select, .physical_upper_addr, .phys_addr_oe, .physical_addr_strobe,
    .strobe_on_rising, .cache_load_inhibit, .bus_fault, .hold_off,
    .logical_request_out, .logical_grant_out, .size_acknowledge, .data_out,
    .data_oe, .reg_write_data, .exc_active);

  mmutb_master mmutb_master_i (.core_clk, .go, .addr, .low,
    .ext_wait(4'h8), .bus_fault, .size_acknowledge, .logical_addr_strobe,
    .logical_upper_addr, .shared_low_addr);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic rst(input logic [7:0] s);
    @(posedge core_clk);
    #1;
    rst_n = 1'h0;
    data_low = s;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    data_low = ~s;
  endtask : rst

  task automatic run(input int k);
    logic [4:0] obs;
    logic [1:0] sk;
    logic [31:0] r;
    logic [23:0] pexp;
    int e, pas_at, flt_at, hold_at, sack_at;
    obs = 5'h0;
    sk = 2'h0;
    pas_at = 0;
    flt_at = 0;
    hold_at = 0;
    sack_at = 0;
    @(posedge core_clk);
    #1;
    {cpu_space, target_self, bkpt_ack_cycle, xlat_hit, xlat_violation,
      reg_needs_search, reg_restart_search, reg_write} = ctab[k];
    bkpt_enabled = (k != 8);
    r = rnd();
    addr = r[23:0];
    low = r[31:24];
    r = rnd();
    initial_shift_field = r[3:0];
    page_extra_bits = r[6:4];
    phys_bus_owned = r[7];
    xlat_page = r[31:8];
    reg_read_data = rnd();
    search_addr = reg_read_data[31:8];
    data_in = rnd();
    for (int i = 0; i < 24; i++)
      pexp[i] = (i < page_extra_bits) ? addr[i] : xlat_page[i];
    go = (k != 9);
    @(posedge core_clk);
    #1;
    go = 1'h0;
    search_cycle = (k == 9);
    for (e = 1; e < 20; e++)
    begin
      @(posedge core_clk);
      #1;
      if (k == 9 && e == 5)
        search_cycle = 1'h0;
      #2;
      obs = obs | {physical_addr_strobe, cache_load_inhibit, bus_fault,
        hold_off, logical_request_out};
      if (physical_addr_strobe === 1'h1 && pas_at == 0)
        pas_at = e;
      if (bus_fault === 1'h1 && flt_at == 0)
        flt_at = e;
      if (hold_off === 1'h1 && hold_at == 0)
        hold_at = e;
      if (size_acknowledge != 2'h0 && sack_at == 0)
      begin
        sack_at = e;
        sk = size_acknowledge;
        if (k == 2) `CHK({data_oe, data_out}, {1'h1, reg_read_data})
        if (k == 3) `CHK(reg_write_data, data_in)
      end
      if (e == 1 && k != 9)
      begin
        `CHK(lookup_addr, (addr & (mmutb_pkg::ADDR_ALL >> initial_shift_field))
          | (cpu_space ? addr & mmutb_pkg::CPU_KEEP : 24'h0))
        `CHK(reg_select, low)
      end
      if (e == 4 && k == 1)
        `CHK(physical_upper_addr, addr)
      if (e == 4 && k == 0)
        `CHK(physical_upper_addr, pexp)
      if (e == 4 && k == 9)
        `CHK(physical_upper_addr, search_addr)
      if (e == 4)
        `CHK(phys_addr_oe, phys_bus_owned)
      if (!(k == 9 ? search_cycle : logical_addr_strobe))
        break;
    end
    // a synchronised strobe is seen low only after the synchroniser lag
    repeat (k == 9 ? 1 : 1 + lag) @(posedge core_clk);
    #3;
    `CHK(physical_addr_strobe, 1'h0)
    `CHK(obs, k == 9 ? {1'h1, inh[0], 3'h0} : etab[k])
    `CHK(sk, (k >= 2 && k <= 4) ? bus[1:0] : 2'h0)
    if (k == 0) `CHK(pas_at, nclk + lag)
    if (k == 9) `CHK(pas_at, (fast != 0 ? 1 : nclk))
    if (k == 6) `CHK(flt_at, nclk + lag)
    if (k == 6) `CHK(hold_at, flt_at)
    if (k == 4) `CHK(sack_at, hold_at + 1)
    if (k == 6) `CHK(exc_active, early[0])
    #8;
    logical_request_in = 1'h1;
    for (e = 1; e < 12; e++)
    begin
      @(posedge core_clk);
      #3;
      if (logical_grant_out === 1'h1)
        break;
    end
    `CHK(e <= ((early != 0 && (k == 4 || k == 6)) ? 9 : 1), 1'h1)
    #8;
    logical_grant_acknowledge = 1'h1;
    logical_request_in = 1'h0;
    repeat (2) @(posedge core_clk);
    #3;
    if (k == 6) `CHK(exc_active, ~early[0])
    #8;
    logical_grant_acknowledge = 1'h0;
    search_done = 1'h1;
    @(posedge core_clk);
    #1;
    search_done = 1'h0;
    repeat (2) @(posedge core_clk);
  endtask : run

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  initial
  begin
    for (code = 0; code < 4; code++)
    begin
      fast = code % 2;
      inh = code / 2;
      early = fast ^ inh;
      bus = code % 3 + 1;
      // whole clocks from one clock base plus 3 - code half clocks
      nclk = (6 - code) / 2;
      rst({inh[0], early[0], fast[0], code[1:0], bus[1:0], 1'h1});
      async_mode = (code == 3);
      // three synchroniser stages plus one for the agreement test
      lag = (code == 3) ? 4 : 0;
      `CHK(strobe_on_rising, ~code[0])
      for (int k = 0; k < 10; k++)
        run(k);
      $display("test %0d done", code);
    end
    summarize();
  end

  // about 800 cycles expected; some thirty times that before giving up
  initial
  begin
    #250000;
    n_fail++;
    summarize();
  end
endmodule : mmu_translation_bus_interface_bench
